// >>> hdl/phy_link_port.sv
// request decoder, pending bus request and status transfer engine
`timescale 1ns/100ps
module phy_link_port
    import phy_link_pkg::*;
(
    // clock and reset
    input  wire logic       SYS_CLK_I,
    input  wire logic       RST_I,
    // serial request line from the link controller (pin)
    input  wire logic       LINK_SERVICE_REQUEST_LINE_I,
    // interface state from the rest of the device
    input  wire logic       RECEIVE_ACTIVE_I,
    input  wire logic       BUS_RESET_I,
    input  wire logic       ARB_WON_I,
    input  wire logic       SELF_ID_DONE_I,
    input  wire flags_type  FLAG_EVENT_I,
    // register file side input for the node address
    input  wire regwr_type  NODE_ID_WR_I,
    // control lines and status data
    output logic      [1:0] INTERFACE_CONTROL_LINES_O,
    output logic      [1:0] STATUS_DATA_O,
    // pending bus request and acceleration state
    output busreq_type      BUS_REQUEST_O,
    output logic      [2:0] BUS_REQUEST_SPEED_O,
    output logic            IMMEDIATE_GRANT_O,
    output logic            ACCEL_ACTIVE_O
);
    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    logic req_meta_ff, req_ff;

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            req_meta_ff <= 1'b0;
            req_ff      <= 1'b0;
        end else begin
            req_meta_ff <= LINK_SERVICE_REQUEST_LINE_I;
            req_ff      <= req_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // serial request shifter
    // ------------------------------------------------------------
    logic        shift_act_ff, nxt_shift_act;
    logic [4:0]  cnt_ff, nxt_cnt;     // bits taken incl start
    logic [15:0] sr_ff, nxt_sr;       // bits after start, MSB first
    logic        done;                // one-cycle: request complete
    logic [2:0]  rtype;
    logic [2:0]  type_ff, nxt_type;   // type held once bit three is in
    logic [2:0]  rspeed;
    logic [3:0]  raddr;
    logic [7:0]  rdata;
    logic        fp_kill;             // receive during fair/pri shift

    // the shifter keeps moving, so the type is latched after bit three
    assign rtype = (cnt_ff == 5'h04) ? sr_ff[2:0] : type_ff;

    // shift one bit per clock, start bit opens, length ends
    always_comb begin
        nxt_shift_act = shift_act_ff;
        nxt_cnt       = cnt_ff;
        nxt_sr        = sr_ff;
        nxt_type      = type_ff;
        done          = 1'b0;
        if (!shift_act_ff) begin
            if (req_ff) begin
                nxt_shift_act = 1'b1;
                nxt_cnt       = 5'h01;
                nxt_sr        = '0;
            end
        end else begin
            nxt_sr  = {sr_ff[14:0], req_ff};
            nxt_cnt = cnt_ff + 5'h01;
            if (cnt_ff == 5'h04) begin
                nxt_type = sr_ff[2:0];
            end
            // length known once type bits are in
            if (cnt_ff >= 5'h04) begin
                unique case (rtype)
                    TYPE_REGISTER_READ_REQUEST: done = (nxt_cnt == LEN_RD);
                    TYPE_REGISTER_WRITE_REQUEST: done = (nxt_cnt == LEN_WR);
                    TYPE_ACCEL: done = (nxt_cnt == LEN_ACCEL);
                    TYPE_RSVD:  done = (nxt_cnt == LEN_BUS7);
                    default: begin
                        // stop may be omitted when speed lsb is 0
                        done = (nxt_cnt == LEN_BUS8) ||
                               (nxt_cnt == LEN_BUS7 && !req_ff);
                    end
                endcase
            end
            if (done) begin
                nxt_shift_act = 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            shift_act_ff <= 1'b0;
            cnt_ff       <= '0;
            sr_ff        <= '0;
            type_ff      <= '0;
        end else begin
            shift_act_ff <= nxt_shift_act;
            cnt_ff       <= nxt_cnt;
            sr_ff        <= nxt_sr;
            type_ff      <= nxt_type;
        end
    end

    // fields from the shifted bits, aligned by request length
    // at done the stop bit sits in bit 0; a 7-bit bus request has none
    assign raddr  = nxt_sr[4:1];
    assign rdata  = nxt_sr[8:1];
    assign rspeed = (nxt_cnt == LEN_BUS8) ? nxt_sr[3:1] : nxt_sr[2:0];

    // ------------------------------------------------------------
    // register memory
    // ------------------------------------------------------------
    regwr_type  reg_wr;
    logic [3:0] rd_addr_ff, nxt_rd_addr;
    logic [7:0] reg_rd_data;
    logic       accel_reg_en;

    // write lands the cycle the last bit arrives
    always_comb begin
        reg_wr = NODE_ID_WR_I;
        if (done && rtype == TYPE_REGISTER_WRITE_REQUEST) begin
            reg_wr.en   = 1'b1;
            reg_wr.addr = nxt_sr[12:9];
            reg_wr.data = rdata;
        end
    end

    phy_regfile #(
        .DEPTH      (REG_COUNT)
    ) u_regs (
        .clk_i      (SYS_CLK_I),
        .rst_i      (RST_I),
        .wr_i       (reg_wr),
        .rd_addr_i  (nxt_rd_addr),
        .rd_data_o  (reg_rd_data),
        .accel_en_o (accel_reg_en)
    );

    // ------------------------------------------------------------
    // pending bus request, acceleration and register read
    // ------------------------------------------------------------
    busreq_type busreq_ff, nxt_busreq;
    logic [2:0] speed_ff, nxt_speed;
    logic       accel_ff, nxt_accel;
    logic       rd_pend_ff, nxt_rd_pend;
    logic       rd_done;          // register delivered this cycle
    logic       recv_prev_ff;
    logic       grant_ff, nxt_grant;

    assign fp_kill = shift_act_ff && RECEIVE_ACTIVE_I &&
                     (rtype == TYPE_PRI || rtype == TYPE_FAIR);

    always_comb begin
        nxt_busreq  = busreq_ff;
        nxt_speed   = speed_ff;
        nxt_accel   = accel_ff;
        nxt_rd_pend = rd_pend_ff;
        nxt_rd_addr = rd_addr_ff;
        nxt_grant   = 1'b0;
        // receive drops fair and priority only
        if (RECEIVE_ACTIVE_I &&
            (busreq_ff == BUSREQ_PRI || busreq_ff == BUSREQ_FAIR)) begin
            nxt_busreq = BUSREQ_NONE;
        end
        // immediate granted at packet end
        if (recv_prev_ff && !RECEIVE_ACTIVE_I &&
            busreq_ff == BUSREQ_IMM) begin
            nxt_grant  = 1'b1;
            nxt_busreq = BUSREQ_NONE;
        end
        if (ARB_WON_I && busreq_ff != BUSREQ_NONE) begin
            nxt_busreq = BUSREQ_NONE;
        end
        if (rd_done) begin
            nxt_rd_pend = 1'b0;
        end
        if (done && !fp_kill) begin
            unique case (rtype)
                TYPE_IMM, TYPE_ISO, TYPE_PRI, TYPE_FAIR: begin
                    if (busreq_ff == BUSREQ_NONE) begin
                        nxt_speed = rspeed;
                        unique case (rtype)
                            TYPE_IMM: nxt_busreq = BUSREQ_IMM;
                            TYPE_ISO: nxt_busreq = BUSREQ_ISO;
                            TYPE_PRI: nxt_busreq = BUSREQ_PRI;
                            default:  nxt_busreq = BUSREQ_FAIR;
                        endcase
                        if (rtype == TYPE_ISO) begin
                            nxt_accel = accel_reg_en;
                        end
                    end
                end
                TYPE_REGISTER_READ_REQUEST: begin
                    if (!rd_pend_ff) begin
                        nxt_rd_pend = 1'b1;
                        nxt_rd_addr = raddr;
                    end
                end
                TYPE_REGISTER_WRITE_REQUEST: ;
                TYPE_ACCEL: nxt_accel = nxt_sr[1];
                TYPE_RSVD:  ;
            endcase
        end
        // node address sent after self-id
        if (SELF_ID_DONE_I && !rd_pend_ff) begin
            nxt_rd_pend = 1'b1;
            nxt_rd_addr = REG_NODE_ID;
        end
        // bus reset: requests gone, read kept
        if (BUS_RESET_I) begin
            nxt_busreq = BUSREQ_NONE;
            nxt_grant  = 1'b0;
            nxt_accel  = accel_reg_en;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            busreq_ff    <= BUSREQ_NONE;
            speed_ff     <= '0;
            accel_ff     <= 1'b0;
            rd_pend_ff   <= 1'b0;
            rd_addr_ff   <= '0;
            recv_prev_ff <= 1'b0;
            grant_ff     <= 1'b0;
        end else begin
            busreq_ff    <= nxt_busreq;
            speed_ff     <= nxt_speed;
            accel_ff     <= nxt_accel;
            rd_pend_ff   <= nxt_rd_pend;
            rd_addr_ff   <= nxt_rd_addr;
            recv_prev_ff <= RECEIVE_ACTIVE_I;
            grant_ff     <= nxt_grant;
        end
    end

    // ------------------------------------------------------------
    // status transfer engine
    // ------------------------------------------------------------
    flags_type   flags_ff, nxt_flags;
    logic        st_act_ff, nxt_st_act;
    logic        gap_ff, nxt_gap;     // forced idle after a transfer
    logic [2:0]  pair_ff, nxt_pair;
    logic        full_ff, nxt_full;
    logic [15:0] word_ff, nxt_word;
    logic [1:0]  ctl_ff, nxt_ctl;
    logic [1:0]  dat_ff, nxt_dat;
    logic        accel_out_ff, nxt_accel_out;

    // flags set wins over clear; sent pairs leave the pending set
    always_comb begin
        nxt_flags  = flags_ff | FLAG_EVENT_I;
        nxt_st_act = st_act_ff;
        nxt_gap    = 1'b0;
        nxt_pair   = pair_ff;
        nxt_full   = full_ff;
        nxt_word   = word_ff;
        nxt_ctl    = CTL_IDLE;
        nxt_dat    = '0;
        rd_done    = 1'b0;
        if (RECEIVE_ACTIVE_I) begin
            // cut short; flags already sent stay sent
            nxt_st_act = 1'b0;
            nxt_ctl    = CTL_RECEIVE;
        end else if (st_act_ff) begin
            nxt_ctl  = CTL_STATUS;
            nxt_dat  = word_ff[15:14];
            nxt_word = {word_ff[13:0], 2'b00};
            nxt_pair = pair_ff + 3'h1;
            if (pair_ff == 3'h0) begin
                nxt_flags.arb_reset_gap = FLAG_EVENT_I.arb_reset_gap;
                nxt_flags.subaction_gap = FLAG_EVENT_I.subaction_gap;
            end
            if (pair_ff == 3'h1) begin
                nxt_flags.bus_reset = FLAG_EVENT_I.bus_reset;
                nxt_flags.intr      = FLAG_EVENT_I.intr;
            end
            // 2 pairs for flags, 8 when a register rides
            if (nxt_pair == (full_ff ? STAT_FULL_PAIRS
                                     : STAT_FLAG_PAIRS)) begin
                nxt_st_act = 1'b0;
                nxt_gap    = 1'b1;
                rd_done    = full_ff;
            end
        end else if (ctl_ff == CTL_IDLE && !gap_ff && !grant_ff &&
                     (flags_ff != '0 || rd_pend_ff)) begin
            // start only from idle, retry whatever remains
            nxt_st_act = 1'b1;
            nxt_full   = rd_pend_ff;
            nxt_pair   = 3'h1;
            nxt_ctl    = CTL_STATUS;
            // bits 0..3 flags, 4..7 addr, 8..15 data
            nxt_dat    = {flags_ff.arb_reset_gap,
                          flags_ff.subaction_gap};
            nxt_word   = {flags_ff.bus_reset, flags_ff.intr,
                          rd_addr_ff, reg_rd_data, 2'b00};
            nxt_flags.arb_reset_gap = FLAG_EVENT_I.arb_reset_gap;
            nxt_flags.subaction_gap = FLAG_EVENT_I.subaction_gap;
        end else if (grant_ff) begin
            nxt_ctl = CTL_GRANT;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            flags_ff  <= '0;
            st_act_ff <= 1'b0;
            gap_ff    <= 1'b0;
            pair_ff   <= '0;
            full_ff   <= 1'b0;
            word_ff   <= '0;
            ctl_ff    <= CTL_IDLE;
            dat_ff    <= '0;
        end else begin
            flags_ff  <= nxt_flags;
            st_act_ff <= nxt_st_act;
            gap_ff    <= nxt_gap;
            pair_ff   <= nxt_pair;
            full_ff   <= nxt_full;
            word_ff   <= nxt_word;
            ctl_ff    <= nxt_ctl;
            dat_ff    <= nxt_dat;
        end
    end

    assign INTERFACE_CONTROL_LINES_O = ctl_ff;
    assign STATUS_DATA_O             = dat_ff;
    assign BUS_REQUEST_O             = busreq_ff;
    assign BUS_REQUEST_SPEED_O       = speed_ff;
    assign IMMEDIATE_GRANT_O         = grant_ff;
    assign ACCEL_ACTIVE_O            = accel_out_ff;

    // acceleration gated by register bit
    assign nxt_accel_out = nxt_accel && accel_reg_en;
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            accel_out_ff <= 1'b0;
        end else begin
            accel_out_ff <= nxt_accel_out;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_iso_held: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        busreq_ff == BUSREQ_ISO && !ARB_WON_I && !BUS_RESET_I
        |=> busreq_ff == BUSREQ_ISO)
        else $error("iso request dropped early");
    a_reset_clears: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        BUS_RESET_I |=> busreq_ff == BUSREQ_NONE)
        else $error("bus reset left a request");
    a_gap_between: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        ctl_ff == CTL_STATUS && !st_act_ff
        |=> ctl_ff != CTL_STATUS)
        else $error("no idle between status");
    a_status_from_idle: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        $rose(st_act_ff) |-> $past(ctl_ff) == CTL_IDLE)
        else $error("status started from non-idle");
    a_fp_dropped: assert property (
        @(posedge SYS_CLK_I) disable iff (RST_I)
        RECEIVE_ACTIVE_I &&
        (busreq_ff == BUSREQ_PRI || busreq_ff == BUSREQ_FAIR)
        |=> busreq_ff != BUSREQ_PRI && busreq_ff != BUSREQ_FAIR)
        else $error("fair or priority kept through receive");
    a_imm_grant: assert property (
        @(posedge SYS_CLK_I) disable iff (RST_I)
        recv_prev_ff && !RECEIVE_ACTIVE_I &&
        busreq_ff == BUSREQ_IMM && !BUS_RESET_I
        |=> grant_ff)
        else $error("immediate grant missing at packet end");
endmodule // phy_link_port

// >>> pkg/phy_link_pkg.sv
// constants and carriers for the link request and status port
package phy_link_pkg;

    // ------------------------------------------------------------
    // request types
    // ------------------------------------------------------------
    localparam logic [2:0] TYPE_IMM   = 3'h0;
    localparam logic [2:0] TYPE_ISO   = 3'h1;
    localparam logic [2:0] TYPE_PRI   = 3'h2;
    localparam logic [2:0] TYPE_FAIR  = 3'h3;
    localparam logic [2:0] TYPE_REGISTER_READ_REQUEST = 3'h4;
    localparam logic [2:0] TYPE_REGISTER_WRITE_REQUEST = 3'h5;
    localparam logic [2:0] TYPE_ACCEL = 3'h6;
    localparam logic [2:0] TYPE_RSVD  = 3'h7;

    // ------------------------------------------------------------
    // request lengths in bits, start and stop included; LEN_BUS7 has no stop bit
    // ------------------------------------------------------------
    localparam logic [4:0] LEN_BUS7  = 5'h07;
    localparam logic [4:0] LEN_BUS8  = 5'h08;
    localparam logic [4:0] LEN_RD    = 5'h09;
    localparam logic [4:0] LEN_WR    = 5'h11;
    localparam logic [4:0] LEN_ACCEL = 5'h06;

    // ------------------------------------------------------------
    // control line codes driven by the device
    // ------------------------------------------------------------
    localparam logic [1:0] CTL_IDLE    = 2'h0;
    localparam logic [1:0] CTL_STATUS  = 2'h1;
    localparam logic [1:0] CTL_RECEIVE = 2'h2;
    localparam logic [1:0] CTL_GRANT   = 2'h3;

    // ------------------------------------------------------------
    // register file and status word
    // ------------------------------------------------------------
    localparam int         REG_COUNT     = 16;
    localparam logic [3:0] REG_ACCEL     = 4'h5;
    localparam int         ACCEL_EN_POS  = 1;
    localparam logic [3:0] REG_NODE_ID   = 4'h0;
    localparam logic [7:0] REG_RESET_VAL = 8'h00;
    localparam logic [2:0] STAT_FLAG_PAIRS = 3'h2;
    localparam logic [2:0] STAT_FULL_PAIRS = 3'h0; // wraps: 8 pairs
    localparam logic [2:0] STAT_DATA_PAIR  = 3'h4; // first data pair

    typedef enum logic [2:0] {
        BUSREQ_NONE = 3'h0,
        BUSREQ_IMM  = 3'h1,
        BUSREQ_ISO  = 3'h2,
        BUSREQ_PRI  = 3'h3,
        BUSREQ_FAIR = 3'h4
    } busreq_type;

    // status flags carried together
    typedef struct packed {
        logic intr;
        logic bus_reset;
        logic subaction_gap;
        logic arb_reset_gap;
    } flags_type;

    // register write carried to the register memory
    typedef struct packed {
        logic       en;
        logic [3:0] addr;
        logic [7:0] data;
    } regwr_type;

endpackage

// >>> hdl/phy_regfile.sv
// small register memory with registered read port
`timescale 1ns/100ps
module phy_regfile
    import phy_link_pkg::*;
#(
    parameter int DEPTH = REG_COUNT
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // write port
    input  wire regwr_type  wr_i,
    // read port
    input  wire logic [3:0] rd_addr_i,
    output logic      [7:0] rd_data_o,
    // acceleration enable bit, always visible
    output logic            accel_en_o
);
    logic [7:0] mem_ff [DEPTH];
    logic [7:0] nxt_mem [DEPTH];
    logic [7:0] rd_ff;
    logic [7:0] nxt_rd;

    // write decode and registered read
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            nxt_mem[i] = mem_ff[i];
        end
        if (wr_i.en) begin
            nxt_mem[wr_i.addr] = wr_i.data;
        end
        nxt_rd = mem_ff[rd_addr_i];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= REG_RESET_VAL;
            end
            rd_ff <= REG_RESET_VAL;
        end else begin
            mem_ff <= nxt_mem;
            rd_ff  <= nxt_rd;
        end
    end

    assign rd_data_o  = rd_ff;
    assign accel_en_o = mem_ff[REG_ACCEL][ACCEL_EN_POS];
endmodule // phy_regfile

// >>> dv/link_model.sv
// link controller model that shifts requests onto the serial line
`timescale 1ns/100ps
module link_model
    import phy_link_pkg::*;
(
    // clock and interface state
    input  wire logic       clk_i,
    input  wire logic [1:0] ctl_i,
    // serial request line
    output logic            req_o
);
    // line rests low between frames
    initial req_o = 1'b0;

    // one bit per clock, msb first; stop bit leaves line low
    task automatic shift(input logic [16:0] v, input int len);
        for (int i = 0; i < len; i++) begin
            @(posedge clk_i);
            req_o <= v[16 - i];
        end
    endtask

    // fair and priority wait for one idle clock first
    task automatic bus_req(input logic [2:0] t, input logic [2:0] s);
        int k = 0;
        while ((t == TYPE_FAIR || t == TYPE_PRI) && ctl_i !== CTL_IDLE
               && k < 200) begin
            @(posedge clk_i);
            k++;
        end
        @(posedge clk_i);
        shift({1'b1, t, s, 1'b0, 9'h000}, 8);
    endtask

    // register read frame, nine bits
    task automatic rd(input logic [3:0] a);
        shift({1'b1, TYPE_REGISTER_READ_REQUEST, a, 1'b0, 8'h00}, 9);
    endtask

    // register write frame, seventeen bits
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        shift({1'b1, TYPE_REGISTER_WRITE_REQUEST, a, d, 1'b0}, 17);
    endtask

    // acceleration control frame, six bits
    task automatic accel(input logic b);
        shift({1'b1, TYPE_ACCEL, b, 1'b0, 11'h000}, 6);
    endtask
endmodule // link_model

// >>> dv/test_phy_link_port.sv
// self-checking bench for the link request and status port
`timescale 1ns/100ps
module test_phy_link_port
    import phy_link_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        req_line;
    logic        rx;
    logic        bus_rst;
    logic        won;
    logic        sid_done;
    flags_type   flags;
    regwr_type   node_wr;
    logic [1:0]  ctl;
    logic [1:0]  sdata;
    busreq_type  breq;
    logic [2:0]  bspeed;
    logic        igrant;
    logic        accel;
    int          n_errors = 0;
    int          samples_checked = 0;
    logic [15:0] w;
    int          n;
    // rows: request type, speed, pending kind expected
    logic [2:0]  rt[4] = '{TYPE_IMM, TYPE_ISO, TYPE_PRI, TYPE_FAIR};
    logic [2:0]  rs[4] = '{3'h0, 3'h2, 3'h4, 3'h1};
    busreq_type  re[4] = '{BUSREQ_IMM, BUSREQ_ISO, BUSREQ_PRI, BUSREQ_FAIR};

    always #4 clk = ~clk;

    phy_link_port uut (
        .SYS_CLK_I(clk), .RST_I(rst), .LINK_SERVICE_REQUEST_LINE_I(req_line),
        .RECEIVE_ACTIVE_I(rx), .BUS_RESET_I(bus_rst), .ARB_WON_I(won),
        .SELF_ID_DONE_I(sid_done), .FLAG_EVENT_I(flags),
        .NODE_ID_WR_I(node_wr), .INTERFACE_CONTROL_LINES_O(ctl),
        .STATUS_DATA_O(sdata), .BUS_REQUEST_O(breq),
        .BUS_REQUEST_SPEED_O(bspeed), .IMMEDIATE_GRANT_O(igrant),
        .ACCEL_ACTIVE_O(accel));

    link_model lm (.clk_i(clk), .ctl_i(ctl), .req_o(req_line));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    // sample away from the edge so updates have landed
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        @(negedge clk);
    endtask

    // arbitration won ends the outstanding request
    task automatic win();
        @(posedge clk);
        won <= 1'b1;
        @(posedge clk);
        won <= 1'b0;
        tick(2);
    endtask

    task automatic rx_for(input int c);
        @(posedge clk);
        rx <= 1'b1;
        repeat (c) @(posedge clk);
        rx <= 1'b0;
    endtask

    // gather one status transfer as pairs, first bit on the high line
    task automatic get_stat(output logic [15:0] wd, output int c);
        int k = 0;
        wd = '0;
        c = 0;
        while (ctl !== CTL_STATUS && k < 300) begin
            @(negedge clk);
            k++;
        end
        while (ctl === CTL_STATUS && c < 9) begin
            wd = {wd[13:0], sdata};
            c++;
            @(negedge clk);
        end
        chk(16'(ctl), 16'(CTL_IDLE));
    endtask

    // count status cycles over a window where none may start
    task automatic quiet();
        int s = 0;
        repeat (30) begin
            @(negedge clk);
            if (ctl === CTL_STATUS) s++;
        end
        chk(16'(s), 16'h0000);
    endtask

    task automatic end_sim();
        $display("errors %0d, comparisons %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // watchdog: the tests need a few thousand cycles at most
    // ----------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_sim();
    end

    initial begin
        rx       <= 1'b0;
        bus_rst  <= 1'b0;
        won      <= 1'b0;
        sid_done <= 1'b0;
        flags    <= '0;
        node_wr  <= '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        chk(16'(ctl), 16'(CTL_IDLE));
        chk(16'(breq), 16'(BUSREQ_NONE));
        // ordinary bus requests, one row each
        for (int i = 0; i < 4; i++) begin
            lm.bus_req(rt[i], rs[i]);
            tick(5);
            chk(16'(breq), 16'(re[i]));
            chk(16'(bspeed), 16'(rs[i]));
            win();
            chk(16'(breq), 16'(BUSREQ_NONE));
        end
        // second request while one pends, then a receive
        lm.bus_req(TYPE_ISO, 3'h2);
        lm.bus_req(TYPE_FAIR, 3'h0);
        rx_for(3);
        tick(5);
        chk(16'(breq), 16'(BUSREQ_ISO));
        win();
        // fair request lost to a receive
        lm.bus_req(TYPE_FAIR, 3'h0);
        tick(5);
        rx_for(3);
        tick(2);
        chk(16'(breq), 16'(BUSREQ_NONE));
        // reserved type leaves everything alone
        lm.bus_req(TYPE_RSVD, 3'h0);
        tick(5);
        chk(16'(breq), 16'(BUSREQ_NONE));
        quiet();
        // immediate request during receive, grant at packet end
        @(posedge clk);
        rx <= 1'b1;
        tick(2);
        chk(16'(ctl), 16'(CTL_RECEIVE));
        lm.bus_req(TYPE_IMM, 3'h0);
        tick(4);
        @(posedge clk);
        rx <= 1'b0;
        n = 0;
        while (igrant !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        chk(16'(igrant), 16'h0001);
        win();
        // write then read back through a full transfer
        lm.wr(4'h3, 8'hA5);
        tick(4);
        lm.rd(4'h3);
        get_stat(w, n);
        chk(w, 16'h03A5);
        chk(16'(n), 16'h0008);
        // flags alone give a short transfer
        @(posedge clk);
        flags <= '{intr: 1'b1, bus_reset: 1'b0, subaction_gap: 1'b0,
                   arb_reset_gap: 1'b1};
        @(posedge clk);
        flags <= '0;
        get_stat(w, n);
        chk(w, 16'h0009);
        chk(16'(n), 16'h0002);
        // second read ignored; first retried after an interruption
        @(posedge clk);
        rx <= 1'b1;
        lm.rd(4'h3);
        lm.rd(4'h5);
        @(posedge clk);
        rx <= 1'b0;
        n = 0;
        while (ctl !== CTL_STATUS && n < 50) begin
            @(negedge clk);
            n++;
        end
        rx_for(3);
        get_stat(w, n);
        chk(w, 16'h03A5);
        chk(16'(n), 16'h0008);
        quiet();
        // acceleration control gated by register 5
        lm.accel(1'b1);
        tick(5);
        chk(16'(accel), 16'h0000);
        lm.wr(REG_ACCEL, 8'h02);
        lm.accel(1'b1);
        tick(5);
        chk(16'(accel), 16'h0001);
        lm.accel(1'b0);
        tick(5);
        chk(16'(accel), 16'h0000);
        lm.bus_req(TYPE_ISO, 3'h0);
        tick(5);
        chk(16'(accel), 16'h0001);
        win();
        lm.wr(REG_ACCEL, 8'h00);
        tick(5);
        chk(16'(accel), 16'h0000);
        // node address returned unasked after self-id
        @(posedge clk);
        node_wr <= '{en: 1'b1, addr: REG_NODE_ID, data: 8'h2C};
        @(posedge clk);
        node_wr <= '0;
        sid_done <= 1'b1;
        @(posedge clk);
        sid_done <= 1'b0;
        get_stat(w, n);
        chk(w, 16'h002C);
        chk(16'(n), 16'h0008);
        // bus reset clears the bus request, keeps the read
        lm.bus_req(TYPE_ISO, 3'h0);
        @(posedge clk);
        rx <= 1'b1;
        lm.rd(4'h3);
        tick(4);
        @(posedge clk);
        bus_rst <= 1'b1;
        @(posedge clk);
        bus_rst <= 1'b0;
        rx <= 1'b0;
        tick(2);
        chk(16'(breq), 16'(BUSREQ_NONE));
        get_stat(w, n);
        chk({4'h0, w[11:0]}, 16'h03A5);
        end_sim();
    end
endmodule // test_phy_link_port
